// file: iac_device.sv
// Device end: register file on the serial host port and automatic input calibration.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "iac_params.svh"

// Function
// - Registers 16 bits, two byte transfers each
// - Write commits only on second byte
// - Read-only show status; write-only trigger transfers
// - Host avoids controller-owned registers while enabled
// - Picture settings writable at all times
// - Software registers use same transfer format
// - Direct host polls line and frame counts
// - Direct host reads edges, computes scaling itself
// - Calibration kept as four ratios times 65536
// - Horizontal ratios over line period
// - Vertical ratios over frame lines
// - Auto and manual modes, four mode table
// - Accept after edges stable 600 ms
// - Defaults after 3 s without stability
// - Out-of-limit ratios rejected; defaults used only if no measured calibration held
// - Keep sampling, replace defaults when stable
// - Adopt new calibration only if larger
// - Auto calibration enabled from reset
// - Host sets default, minimum, maximum values
// - Restart bit discards and reacquires calibration
module iac_device #(
  parameter int MS_CYCLES  = `IAC_MS_NS / `IAC_CLK_NS,
  parameter int STABLE_MS  = `IAC_STABLE_MS,
  parameter int TIMEOUT_MS = `IAC_TIMEOUT_MS
) (
  // Serial host port
  iac_link_if.dev         link,
  // Input measurements
  input  wire logic [15:0] input_line_period_count,
  input  wire logic [15:0] input_frame_line_count,
  input  wire logic [15:0] h_start_measure,
  input  wire logic [15:0] h_end_measure,
  input  wire logic [15:0] v_start_measure,
  input  wire logic [15:0] v_end_measure,
  input  wire logic [1:0]  video_mode,
  // Calibration towards the scaler
  output logic      [15:0] h_start_ratio,
  output logic      [15:0] h_active_ratio,
  output logic      [15:0] v_start_ratio,
  output logic      [15:0] v_active_ratio,
  output logic             cal_valid,
  output logic             auto_cal_disable,
  // Picture settings
  output logic      [15:0] luma_gain_setting,
  output logic      [15:0] luma_offset_setting,
  output logic      [15:0] edge_enhance_level,
  output logic      [15:0] chroma_saturation_level
);
  localparam int TW = $clog2(MS_CYCLES + 1);

  if (MS_CYCLES < 1 || STABLE_MS < 1 || STABLE_MS >= TIMEOUT_MS || TIMEOUT_MS > 4095)
  begin : g_bad_params
    $error("iac_device: unusable timing parameters");
  end

  typedef struct packed {
    logic [3:0][15:0]       hw;
    logic                   dis;
    logic [3:0]             cidx;
    logic [15:0][15:0]      cfg;
    logic [7:0]             wlow;
    logic [15:0]            rhold;
    logic [7:0]             rbyte;
    logic                   rvalid;
    logic [TW-1:0]          tick;
    logic [3:0][15:0]       prev;
    logic [11:0]            stab;
    logic [11:0]            waitc;
    iac_pkg::iac_cal_e      st;
    logic [1:0]             di;
    logic [4:0]             bc;
    logic [16:0]            rem;
    logic [15:0]            quo;
    logic [3:0][15:0]       calc;
    logic [3:0][3:0][15:0]  tbl;
    logic [3:0]             have;
    logic [3:0]             dflt;
    logic [1:0]             mode;
    logic [3:0][15:0]       ratio;
    logic                   cvalid;
  } iac_dev_s;

  iac_dev_s         q;
  iac_dev_s         d;
  logic [15:0]      num_w;
  logic [15:0]      den_w;
  logic [15:0]      rd_w;
  logic [16:0]      shl_w;
  logic             in_range;
  logic             tick_w;
  logic             restart_w;
  logic             commit_w;
  logic [15:0]      wword_w;
  logic [3:0][15:0] edges_w;
  logic [3:0][15:0] defs_w;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] iac_area(input logic [3:0][15:0] r);
    return r[1] * r[3];
  endfunction : iac_area

  assign edges_w   = {v_end_measure, v_start_measure, h_end_measure, h_start_measure};
  assign defs_w    = q.cfg[`IAC_CFG_DEF_BASE +: 4];
  assign tick_w    = (q.tick == TW'(MS_CYCLES - 1));
  // The second byte carries the high half; the first byte was held in wlow.
  assign commit_w  = link.xfer_valid & link.xfer_write & ~link.xfer_first;
  assign wword_w   = {link.xfer_wbyte, q.wlow};
  assign restart_w = commit_w & (link.xfer_addr == `IAC_A_SYS_CTRL) & q.wlow[`IAC_SCW_RST_BIT];
  assign shl_w     = {q.rem[15:0], 1'b0};

  always_comb
  begin
    case (q.di)
      2'd0:    begin num_w = h_start_measure; den_w = input_line_period_count; end
      2'd1:    begin num_w = h_end_measure - h_start_measure; den_w = input_line_period_count; end
      2'd2:    begin num_w = v_start_measure; den_w = input_frame_line_count; end
      default: begin num_w = v_end_measure - v_start_measure; den_w = input_frame_line_count; end
    endcase
  end

  always_comb
  begin
    in_range = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (q.calc[i] < q.cfg[`IAC_CFG_MIN_BASE + i] || q.calc[i] > q.cfg[`IAC_CFG_MAX_BASE + i])
      begin
        in_range = 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register read decode
  always_comb
  begin
    case (link.xfer_addr)
      `IAC_A_LUMA_GAIN, `IAC_A_LUMA_OFFSET, `IAC_A_EDGE_ENHANCE, `IAC_A_CHROMA_SAT:
        rd_w = q.hw[link.xfer_addr[1:0]];
      `IAC_A_LINE_PERIOD:  rd_w = input_line_period_count;
      `IAC_A_FRAME_LINES:  rd_w = input_frame_line_count;
      `IAC_A_H_START_MEAS: rd_w = h_start_measure;
      `IAC_A_H_END_MEAS:   rd_w = h_end_measure;
      `IAC_A_V_START_MEAS: rd_w = v_start_measure;
      `IAC_A_V_END_MEAS:   rd_w = v_end_measure;
      8'h0a, 8'h0b, 8'h0c, 8'h0d:
        rd_w = q.ratio[2'(link.xfer_addr - `IAC_A_RATIO_BASE)];
      `IAC_A_SYS_CTRL:     rd_w = {15'h0000, q.dis};
      `IAC_A_CFG_INDEX:    rd_w = {12'h000, q.cidx};
      `IAC_A_CFG_VALUE:    rd_w = q.cfg[q.cidx];
      `IAC_A_CAL_STATUS:   rd_w = {12'h000, q.st, q.dflt[q.mode], q.have[q.mode]};
      default:             rd_w = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    d = q;
    d.rvalid = 1'b0;
    d.tick = tick_w ? '0 : q.tick + TW'(1);
    if (link.xfer_valid)
    begin
      if (link.xfer_write && link.xfer_first)
      begin
        d.wlow = link.xfer_wbyte;
      end
      else if (!link.xfer_write)
      begin
        d.rvalid = 1'b1;
        // The word is frozen on the first byte so both halves match.
        if (link.xfer_first)
        begin
          d.rhold = rd_w;
          d.rbyte = rd_w[7:0];
        end
        else
        begin
          d.rbyte = q.rhold[15:8];
        end
      end
    end
    if (commit_w)
    begin
      case (link.xfer_addr)
        `IAC_A_LUMA_GAIN, `IAC_A_LUMA_OFFSET, `IAC_A_EDGE_ENHANCE, `IAC_A_CHROMA_SAT:
          d.hw[link.xfer_addr[1:0]] = wword_w;
        `IAC_A_SYS_CTRL:  d.dis = wword_w[`IAC_SCW_DIS_BIT];
        `IAC_A_CFG_INDEX: d.cidx = wword_w[3:0];
        `IAC_A_CFG_VALUE: d.cfg[q.cidx] = wword_w;
        default:          d.dis = q.dis;
      endcase
    end

    if (video_mode != q.mode || restart_w)
    begin
      d.mode  = video_mode;
      d.stab  = '0;
      d.waitc = '0;
      d.st    = iac_pkg::IAC_D_SAMPLE;
      if (restart_w)
      begin
        d.have[q.mode] = 1'b0;
        d.dflt[q.mode] = 1'b0;
      end
    end
    else
    begin
      if (tick_w && q.waitc != 12'(TIMEOUT_MS))
      begin
        d.waitc = q.waitc + 12'd1;
      end
      if (q.waitc == 12'(TIMEOUT_MS) && !q.have[q.mode])
      begin
        d.tbl[q.mode]  = defs_w;
        d.have[q.mode] = 1'b1;
        d.dflt[q.mode] = 1'b1;
      end
      case (q.st)
        iac_pkg::IAC_D_SAMPLE:
        begin
          if (tick_w)
          begin
            d.prev = edges_w;
            d.stab = (edges_w != q.prev) ? 12'd0 : q.stab + 12'd1;
            if (edges_w == q.prev && q.stab == 12'(STABLE_MS - 1))
            begin
              d.st = iac_pkg::IAC_D_DIV;
              d.di = 2'd0;
              d.bc = 5'd0;
            end
          end
        end
        iac_pkg::IAC_D_DIV:
        begin
          if (q.bc == 5'd0)
          begin
            d.rem = {1'b0, num_w};
            d.quo = 16'h0000;
            d.bc  = 5'd1;
            if (den_w == 16'h0000 || num_w >= den_w)
            begin
              d.calc[q.di] = 16'hffff;
              d.bc = 5'd0;
              d.di = q.di + 2'd1;
              d.st = (q.di == 2'd3) ? iac_pkg::IAC_D_CHECK : iac_pkg::IAC_D_DIV;
            end
          end
          else
          begin
            // One quotient bit of num * 65536 / den per cycle.
            d.rem = (shl_w >= {1'b0, den_w}) ? shl_w - {1'b0, den_w} : shl_w;
            d.quo = {q.quo[14:0], shl_w >= {1'b0, den_w}};
            d.bc  = q.bc + 5'd1;
            if (q.bc == 5'd16)
            begin
              d.calc[q.di] = {q.quo[14:0], shl_w >= {1'b0, den_w}};
              d.bc = 5'd0;
              d.di = q.di + 2'd1;
              d.st = (q.di == 2'd3) ? iac_pkg::IAC_D_CHECK : iac_pkg::IAC_D_DIV;
            end
          end
        end
        iac_pkg::IAC_D_CHECK:
        begin
          d.st   = iac_pkg::IAC_D_SAMPLE;
          d.stab = 12'd0;
          if (in_range)
          begin
            if (!q.have[q.mode] || q.dflt[q.mode] ||
                iac_area(q.calc) > iac_area(q.tbl[q.mode]))
            begin
              d.tbl[q.mode]  = q.calc;
              d.have[q.mode] = 1'b1;
              d.dflt[q.mode] = 1'b0;
            end
          end
          else if (!q.have[q.mode] || q.dflt[q.mode])
          begin
            d.tbl[q.mode]  = defs_w;
            d.have[q.mode] = 1'b1;
            d.dflt[q.mode] = 1'b1;
          end
        end
        default: d.st = iac_pkg::IAC_D_SAMPLE;
      endcase
    end

    for (int i = 0; i < 4; i++)
    begin
      d.ratio[i] = q.dis ? q.cfg[`IAC_CFG_MAN_BASE + i] :
                   (q.have[q.mode] ? q.tbl[q.mode][i] : defs_w[i]);
    end
    d.cvalid = q.dis | q.have[q.mode];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge link.clk or negedge link.rst_b)
  begin
    if (!link.rst_b)
    begin
      q <= '0;
      for (int i = 0; i < 4; i++)
      begin
        q.hw[i]                       <= `IAC_RST_SETTING;
        q.cfg[`IAC_CFG_DEF_BASE + i]  <= i[0] ? `IAC_RST_ACTIVE : `IAC_RST_START;
        q.cfg[`IAC_CFG_MIN_BASE + i]  <= `IAC_RST_MIN;
        q.cfg[`IAC_CFG_MAX_BASE + i]  <= `IAC_RST_MAX;
        q.cfg[`IAC_CFG_MAN_BASE + i]  <= i[0] ? `IAC_RST_ACTIVE : `IAC_RST_START;
        q.ratio[i]                    <= i[0] ? `IAC_RST_ACTIVE : `IAC_RST_START;
      end
    end
    else
    begin
      q <= d;
    end
  end

  assign link.rbyte_valid        = q.rvalid;
  assign link.rbyte              = q.rbyte;
  assign h_start_ratio           = q.ratio[0];
  assign h_active_ratio          = q.ratio[1];
  assign v_start_ratio           = q.ratio[2];
  assign v_active_ratio          = q.ratio[3];
  assign cal_valid               = q.cvalid;
  assign auto_cal_disable        = q.dis;
  assign luma_gain_setting       = q.hw[0];
  assign luma_offset_setting     = q.hw[1];
  assign edge_enhance_level      = q.hw[2];
  assign chroma_saturation_level = q.hw[3];
endmodule : iac_device

// file: iac_host.sv
// Host end: turns software commands into two-byte transfers and polls the input size.
`timescale 1ns/1ns
`include "iac_params.svh"

module iac_host (
  // Serial host port
  iac_link_if.host         link,
  // Software port
  input  wire logic [7:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata
);
  typedef struct packed {
    logic [7:0]             cmd_addr;
    logic [15:0]            cmd_data;
    logic                   pend;
    logic                   pend_wr;
    logic                   direct;
    logic                   refused;
    iac_pkg::iac_host_e     st;
    logic                   cur_poll;
    logic [2:0]             poll_i;
    logic [7:0]             rlow;
    logic [15:0]            last_rd;
    logic [5:0][15:0]       shadow;
    logic                   xv;
    logic                   xw;
    logic                   xf;
    logic [7:0]             xa;
    logic [7:0]             xd;
    logic [15:0]            rdata;
  } iac_host_s;

  iac_host_s   q;
  iac_host_s   d;
  logic [15:0] word_w;

  function automatic logic iac_owned(input logic [7:0] a);
    return a >= `IAC_A_OWN_LO && a <= `IAC_A_OWN_HI;
  endfunction : iac_owned

  assign word_w = {link.rbyte, q.rlow};

  always_comb
  begin
    d = q;
    d.xv = 1'b0;
    if (sw_wr)
    begin
      case (sw_addr)
        `IAC_H_CMD_ADDR: d.cmd_addr = sw_addr == `IAC_H_CMD_ADDR ? sw_wdata[7:0] : q.cmd_addr;
        `IAC_H_CMD_DATA: d.cmd_data = sw_wdata;
        `IAC_H_CMD_GO:
        begin
          // Controller-owned registers stay untouched unless software runs direct.
          if (sw_wdata[0] && !q.direct && iac_owned(q.cmd_addr))
          begin
            d.refused = 1'b1;
          end
          else
          begin
            d.pend    = 1'b1;
            d.pend_wr = sw_wdata[0];
          end
        end
        `IAC_H_STATUS:
          if (sw_wdata[`IAC_H_STAT_CLR_BIT])
          begin
            d.refused = 1'b0;
          end
        `IAC_H_CTRL:     d.direct = sw_wdata[0];
        default:         d.direct = q.direct;
      endcase
    end
    if (sw_rd)
    begin
      case (sw_addr)
        `IAC_H_CMD_ADDR: d.rdata = {8'h00, q.cmd_addr};
        `IAC_H_CMD_DATA: d.rdata = q.cmd_data;
        `IAC_H_STATUS:   d.rdata = {13'h0000, q.refused, q.direct,
                                    q.pend || q.st != iac_pkg::IAC_H_IDLE};
        `IAC_H_RDATA:    d.rdata = q.last_rd;
        `IAC_H_CTRL:     d.rdata = {15'h0000, q.direct};
        8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d:
          d.rdata = q.shadow[3'(sw_addr - `IAC_H_SHADOW_BASE)];
        default:         d.rdata = 16'h0000;
      endcase
    end

    case (q.st)
      iac_pkg::IAC_H_IDLE:
      begin
        if (q.pend)
        begin
          d.pend     = 1'b0;
          d.cur_poll = 1'b0;
          d.xv = 1'b1;
          d.xw = q.pend_wr;
          d.xf = 1'b1;
          d.xa = q.cmd_addr;
          d.xd = q.cmd_data[7:0];
          d.st = iac_pkg::IAC_H_B1;
        end
        else if (q.direct)
        begin
          // Measurement registers sit in order from the line period count up.
          d.cur_poll = 1'b1;
          d.xv = 1'b1;
          d.xw = 1'b0;
          d.xf = 1'b1;
          d.xa = `IAC_A_LINE_PERIOD + 8'(q.poll_i);
          d.xd = 8'h00;
          d.st = iac_pkg::IAC_H_B1;
        end
      end
      iac_pkg::IAC_H_B1:
      begin
        d.xv = 1'b1;
        d.xf = 1'b0;
        d.xd = q.cur_poll ? 8'h00 : q.cmd_data[15:8];
        d.st = q.xw ? iac_pkg::IAC_H_IDLE : iac_pkg::IAC_H_WAIT;
      end
      iac_pkg::IAC_H_WAIT:
      begin
        // The low byte answers while the second read byte is still on the link.
        if (link.rbyte_valid && q.xv)
        begin
          d.rlow = link.rbyte;
        end
        else if (link.rbyte_valid)
        begin
          d.st = iac_pkg::IAC_H_IDLE;
          if (q.cur_poll)
          begin
            d.shadow[q.poll_i] = word_w;
            d.poll_i = (q.poll_i == 3'd5) ? 3'd0 : q.poll_i + 3'd1;
          end
          else
          begin
            d.last_rd = word_w;
          end
        end
      end
      default: d.st = iac_pkg::IAC_H_IDLE;
    endcase
  end

  always_ff @(posedge link.clk or negedge link.rst_b)
  begin
    if (!link.rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.xfer_valid = q.xv;
  assign link.xfer_write = q.xw;
  assign link.xfer_first = q.xf;
  assign link.xfer_addr  = q.xa;
  assign link.xfer_wbyte = q.xd;
  assign sw_rdata        = q.rdata;
endmodule : iac_host

// file: iac_link_if.sv
// Byte-wide serial host port joining the host controller and the device.
`timescale 1ns/1ns
interface iac_link_if (
  input wire logic clk,
  input wire logic rst_b
);
  logic       xfer_valid;
  logic       xfer_write;
  logic       xfer_first;
  logic [7:0] xfer_addr;
  logic [7:0] xfer_wbyte;
  logic [7:0] rbyte;
  logic       rbyte_valid;

  modport dev (
    input  clk, rst_b, xfer_valid, xfer_write, xfer_first, xfer_addr, xfer_wbyte,
    output rbyte, rbyte_valid
  );
  modport host (
    input  clk, rst_b, rbyte, rbyte_valid,
    output xfer_valid, xfer_write, xfer_first, xfer_addr, xfer_wbyte
  );
endinterface : iac_link_if

// file: iac_link_sva.sv
// Protocol assertions on the byte link between the host and device ends.
`timescale 1ns/1ns
module iac_link_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Host to device
  input wire logic       xfer_valid,
  input wire logic       xfer_write,
  input wire logic       xfer_first,
  input wire logic [7:0] xfer_addr,
  input wire logic [7:0] xfer_wbyte,
  // Device to host
  input wire logic [7:0] rbyte,
  input wire logic       rbyte_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ==================
  // Byte pairing
  a_first_then_second: assert property (
    xfer_valid && xfer_first |=> xfer_valid && !xfer_first)
    else $error("first byte not followed by second byte");
  a_second_needs_first: assert property (
    xfer_valid && !xfer_first |-> $past(xfer_valid) && $past(xfer_first))
    else $error("second byte without first byte");
  a_pair_same_addr: assert property (
    xfer_valid && xfer_first |=> $stable(xfer_addr))
    else $error("address changed inside a word");
  a_pair_same_dir: assert property (
    xfer_valid && xfer_first |=> xfer_write == $past(xfer_write))
    else $error("direction changed inside a word");

  // ==================
  // Read answers
  a_read_two_bytes: assert property (
    xfer_valid && xfer_first && !xfer_write |=> rbyte_valid [*2])
    else $error("read word not answered with two bytes");
  a_no_stray_rbyte: assert property (
    rbyte_valid |-> $past(xfer_valid) && !$past(xfer_write))
    else $error("read byte without a read transfer");
  a_write_no_answer: assert property (
    xfer_valid && xfer_write |=> !rbyte_valid)
    else $error("write transfer answered with a read byte");
  a_rbyte_holds: assert property (
    !rbyte_valid |-> $stable(rbyte))
    else $error("read byte changed outside an answer");
endmodule : iac_link_sva

// file: iac_params.svh
// Register map, field positions, reset values and timing for input calibration.
`ifndef IAC_PARAMS_SVH
`define IAC_PARAMS_SVH

// ==========================================================================
// Device register addresses on the serial host port
`define IAC_A_LUMA_GAIN     8'h00
`define IAC_A_LUMA_OFFSET   8'h01
`define IAC_A_EDGE_ENHANCE  8'h02
`define IAC_A_CHROMA_SAT    8'h03
`define IAC_A_LINE_PERIOD   8'h04
`define IAC_A_FRAME_LINES   8'h05
`define IAC_A_H_START_MEAS  8'h06
`define IAC_A_H_END_MEAS    8'h07
`define IAC_A_V_START_MEAS  8'h08
`define IAC_A_V_END_MEAS    8'h09
`define IAC_A_RATIO_BASE    8'h0a
`define IAC_A_SYS_CTRL      8'h0e
`define IAC_A_CFG_INDEX     8'h0f
`define IAC_A_CFG_VALUE     8'h10
`define IAC_A_CAL_STATUS    8'h11
`define IAC_A_OWN_LO        8'h04
`define IAC_A_OWN_HI        8'h0d

// ==========================================================================
// Fields
`define IAC_SCW_DIS_BIT     0
`define IAC_SCW_RST_BIT     1
`define IAC_CFG_DEF_BASE    4'h0
`define IAC_CFG_MIN_BASE    4'h4
`define IAC_CFG_MAX_BASE    4'h8
`define IAC_CFG_MAN_BASE    4'hc

// ==========================================================================
// Reset values
`define IAC_RST_START       16'h0800
`define IAC_RST_ACTIVE      16'he000
`define IAC_RST_MIN         16'h0000
`define IAC_RST_MAX         16'hffff
`define IAC_RST_SETTING     16'h0080

// ==========================================================================
// Timing
`define IAC_CLK_NS          10
`define IAC_MS_NS           1000000
`define IAC_STABLE_MS       600
`define IAC_TIMEOUT_MS      3000

// ==========================================================================
// Host controller software port addresses
`define IAC_H_CMD_ADDR      8'h00
`define IAC_H_CMD_DATA      8'h01
`define IAC_H_CMD_GO        8'h02
`define IAC_H_STATUS        8'h03
`define IAC_H_RDATA         8'h04
`define IAC_H_CTRL          8'h05
`define IAC_H_SHADOW_BASE   8'h08
`define IAC_H_STAT_CLR_BIT  1

`endif

// file: iac_pkg.sv
// Types shared by both ends of the input calibration link.
package iac_pkg;
  typedef enum logic [1:0] {IAC_D_SAMPLE, IAC_D_DIV, IAC_D_CHECK} iac_cal_e;
  typedef enum logic [1:0] {IAC_H_IDLE, IAC_H_B1, IAC_H_WAIT} iac_host_e;
  typedef logic [15:0] iac_word_t;
endpackage : iac_pkg

// file: test_input_active_calibration.sv
// Testbench joining host and device ends and checking them from the software side.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_input_active_calibration;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         sw_addr = 8'h00;
  logic [15:0]        sw_wdata = 16'h0000;
  logic               sw_wr = 1'b0;
  logic               sw_rd = 1'b0;
  logic               rd_d1 = 1'b0;
  logic [15:0]        sw_rdata;
  logic [15:0]        lp = 16'd1138;
  logic [15:0]        fl = 16'd806;
  logic [15:0]        hs = 16'd57;
  logic [15:0]        he = 16'd1081;
  logic [15:0]        vs = 16'd35;
  logic [15:0]        ve = 16'd803;
  logic [1:0]         vm = 2'h0;
  iac_pkg::iac_word_t ratio [4];
  iac_pkg::iac_word_t setting [4];
  logic               cal_valid;
  logic               auto_cal_disable;
  logic [15:0]        exp_q [$];
  logic [15:0]        e_v;
  logic [15:0]        wv;
  logic [15:0]        dh;
  logic [63:0]        cal_exp;
  integer             seed = 32'h7bb9;
  int                 num_errors = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;

  always #5 clk = ~clk;

  // ==================
  // Two ends and the link
  iac_link_if iac_link_if_inst (.clk(clk), .rst_b(rst_b));
  iac_host iac_host_inst (.link(iac_link_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  iac_device #(.MS_CYCLES(10), .STABLE_MS(4), .TIMEOUT_MS(20)) iac_device_inst (
    .link(iac_link_if_inst), .input_line_period_count(lp), .input_frame_line_count(fl),
    .h_start_measure(hs), .h_end_measure(he), .v_start_measure(vs), .v_end_measure(ve),
    .video_mode(vm), .h_start_ratio(ratio[0]), .h_active_ratio(ratio[1]),
    .v_start_ratio(ratio[2]), .v_active_ratio(ratio[3]), .cal_valid(cal_valid),
    .auto_cal_disable(auto_cal_disable), .luma_gain_setting(setting[0]),
    .luma_offset_setting(setting[1]), .edge_enhance_level(setting[2]),
    .chroma_saturation_level(setting[3]));
  iac_link_sva iac_link_sva_inst (.clk(clk), .rst_b(rst_b),
    .xfer_valid(iac_link_if_inst.xfer_valid), .xfer_write(iac_link_if_inst.xfer_write),
    .xfer_first(iac_link_if_inst.xfer_first), .xfer_addr(iac_link_if_inst.xfer_addr),
    .xfer_wbyte(iac_link_if_inst.xfer_wbyte), .rbyte(iac_link_if_inst.rbyte),
    .rbyte_valid(iac_link_if_inst.rbyte_valid));

  // ==================
  // Helpers
  function automatic logic [15:0] rat(input logic [15:0] n, input logic [15:0] d);
    logic [31:0] q;
    q = {n, 16'h0000} / {16'h0000, d};
    return (d == 16'h0000 || n >= d) ? 16'hffff : q[15:0];
  endfunction : rat

  function automatic logic [63:0] exp_cal();
    return {rat(hs, lp), rat(he - hs, lp), rat(vs, fl), rat(ve - vs, fl)};
  endfunction : exp_cal

  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr    <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd   <= 1'b0;
  endtask : sw_read

  // The host walk is fixed, so a fixed wait covers the whole word transfer.
  task automatic dev_cmd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] go);
    sw_write(8'h00, {8'h00, a});
    sw_write(8'h01, d);
    sw_write(8'h02, go);
    repeat (8) @(posedge clk);
  endtask : dev_cmd

  task automatic dev_read(input logic [7:0] a, input logic [15:0] e);
    dev_cmd(a, 16'h0000, 16'h0000);
    sw_read(8'h04, e);
  endtask : dev_read

  task automatic chk_cal(input logic [63:0] e);
    for (int i = 0; i < 4; i++)
      `CHK("ratio", e[63 - 16 * i -: 16], ratio[i])
  endtask : chk_cal

  task automatic wait_cal();
    repeat (250) @(posedge clk);
    #1;
  endtask : wait_cal

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // ==================
  // Read data monitor and hang guard
  always @(posedge clk)
  begin
    if (rd_d1)
    begin
      e_v = exp_q.pop_front();
      `CHK("sw_rdata", e_v, sw_rdata)
    end
    rd_d1 <= sw_rd;
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // ==================
  // Scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk_cal({16'h0800, 16'he000, 16'h0800, 16'he000});
    `CHK("auto_cal_disable", 1'b0, auto_cal_disable)
    for (int i = 0; i < 4; i++)
      `CHK("setting", 16'h0080, setting[i])
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wv = $random(seed);
      dev_cmd(8'(i), wv, 16'h0001);
      `CHK("setting", wv, setting[i])
      dev_read(8'(i), wv);
    end
    $display("test picture settings done");
    wait_cal();
    `CHK("cal_valid", 1'b1, cal_valid)
    cal_exp = exp_cal();
    chk_cal(cal_exp);
    dev_read(8'h0b, cal_exp[47:32]);
    dev_read(8'h20, 16'h0000);
    sw_read(8'h07, 16'h0000);
    he <= he - 16'd100;
    wait_cal();
    chk_cal(cal_exp);
    @(posedge clk);
    he <= hs + 16'd1080;
    wait_cal();
    chk_cal(exp_cal());
    @(posedge clk);
    vm <= 2'h1;
    repeat (3) @(posedge clk);
    #1;
    chk_cal({16'h0800, 16'he000, 16'h0800, 16'he000});
    `CHK("cal_valid", 1'b0, cal_valid)
    @(posedge clk);
    vm <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
    chk_cal(exp_cal());
    dev_cmd(8'h0e, 16'h0001, 16'h0001);
    chk_cal({16'h0800, 16'he000, 16'h0800, 16'he000});
    `CHK("auto_cal_disable", 1'b1, auto_cal_disable)
    dev_cmd(8'h0e, 16'h0000, 16'h0001);
    $display("test auto calibration done");
    dev_cmd(8'h0a, 16'h1234, 16'h0001);
    sw_read(8'h03, 16'h0004);
    sw_write(8'h03, 16'h0002);
    sw_read(8'h03, 16'h0000);
    $display("test refusal done");
    dh = $random(seed);
    dev_cmd(8'h0f, 16'h0000, 16'h0001);
    dev_cmd(8'h10, dh, 16'h0001);
    dev_cmd(8'h0f, 16'h0009, 16'h0001);
    dev_cmd(8'h10, 16'h0100, 16'h0001);
    dev_cmd(8'h0e, 16'h0002, 16'h0001);
    wait_cal();
    chk_cal({dh, 16'he000, 16'h0800, 16'he000});
    dev_cmd(8'h10, 16'hffff, 16'h0001);
    wait_cal();
    chk_cal(exp_cal());
    dev_cmd(8'h0e, 16'h0002, 16'h0001);
    repeat (20)
    begin
      wv = $random(seed);
      hs <= {8'h00, wv[7:0]};
      repeat (15) @(posedge clk);
    end
    #1;
    chk_cal({dh, 16'he000, 16'h0800, 16'he000});
    $display("test limits and fallback done");
    sw_write(8'h05, 16'h0001);
    repeat (80) @(posedge clk);
    sw_read(8'h08, lp);
    sw_read(8'h0a, hs);
    $display("test direct polling done");
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : test_input_active_calibration
